// ===== logic/pee_host_ctrl.sv
// host controller driving a byte-wide parallel eeprom through its pins
// assumes pull-up on the ready/busy line and one user on the command port
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RL1: one internal write commits 1 to 64 loaded bytes.
// RL2: host loads each next byte within 30 us.
// RL3: write starts once strobes stay high 100 us.
// RL4: busy reads return the polling bit inverted.
// RL5: toggle bit flips per read while busy, then stops.
// RL6: first busy read shows toggle bit one.
// RL7: toggle polling keeps one fixed address.
// RL8: ready/busy floats, then low after first strobe.
// RL9: ready/busy floats again when the write ends.
// RL10: protect reset low refuses reads and writes.
// RL11: host holds protect reset high during accesses.
// RL12: protect reset low aborts a running write.
// RL13: protect reset stays high 10 ms after last byte.
// RL14: address taken at strobe fall, data at rise.
// RL15: control glitches of 15 ns or less are ignored.
// RL16: host keeps chip select or write strobe high.
// RL17: locked writes need the 3-byte code first.
// RL18: the 3-byte code alone turns the lock on.
// RL19: the 6-byte disable sequence turns the lock off.
// RL20: disable sequence bytes are never programmed.
// RL21: lock is off at delivery.
// RL22: first byte fixes the page bits for all bytes.
// RL23: every internal write ends within 10 ms.
// RL24: lock code is two unlock bytes plus a lock byte.
module pee_host_ctrl #(
  parameter int unsigned                    BL_CYC   = pee_pkg::BL_CYC,
  parameter int unsigned                    WC_CYC   = pee_pkg::WC_CYC,
  parameter int unsigned                    HOLD_CYC = pee_pkg::HOLD_CYC,
  parameter logic [pee_pkg::DATA_W-1:0]     LOCK_CMD = pee_pkg::CODE_LOCK_DF
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         arst_n_i,
  // user side
  input  wire logic                         buf_we_i,
  input  wire logic [pee_pkg::PAGE_OFS_W-1:0] buf_addr_i,
  input  wire logic [pee_pkg::DATA_W-1:0]   buf_data_i,
  input  wire logic                         cmd_valid_i,
  input  wire logic [1:0]                   cmd_op_i,
  input  wire logic [pee_pkg::ADDR_W-1:0]   cmd_addr_i,
  input  wire logic [pee_pkg::LEN_W-1:0]    cmd_len_i,
  input  wire logic [1:0]                   poll_mode_i,
  input  wire logic                         hold_prot_i,
  output logic                              cmd_ready_o,
  output logic                              done_o,
  output logic                              err_o,
  output logic [pee_pkg::DATA_W-1:0]        rdata_o,
  output logic                              rdata_valid_o,
  output logic                              lock_active_o,
  // eeprom pins
  output logic [pee_pkg::ADDR_W-1:0]        mem_addr_o,
  output logic [pee_pkg::DATA_W-1:0]        mem_dq_o,
  output logic                              mem_dq_oe_n_o,
  input  wire logic [pee_pkg::DATA_W-1:0]   mem_dq_i,
  output logic                              mem_ce_n_o,
  output logic                              mem_oe_n_o,
  output logic                              mem_we_n_o,
  output logic                              protect_reset_n_o,
  input  wire logic                         mem_ready_i
);

  localparam int unsigned AW = pee_pkg::ADDR_W;
  localparam int unsigned DW = pee_pkg::DATA_W;
  localparam int unsigned TW = pee_pkg::TMR_W;

  // each byte load must finish before the next-byte deadline
  if (BL_CYC < 1 || WC_CYC < 1 || HOLD_CYC < 1 || BL_CYC >= 2**TW
      || WC_CYC >= 2**TW || HOLD_CYC >= 2**TW
      || pee_pkg::SETUP_CYC + pee_pkg::WE_LOW_CYC + pee_pkg::WE_HIGH_CYC
         >= pee_pkg::BLC_MAX_CYC)
  begin : g_chk
    $error("timing parameters out of range for the counters");
  end

  typedef enum logic [2:0] {
    PEE_IDLE, PEE_W_SETUP, PEE_W_LOW, PEE_W_HIGH, PEE_WAIT_BL, PEE_R_ACT, PEE_R_GAP
  } pee_state_t;

  typedef struct packed {
    pee_state_t                    state;
    logic [TW-1:0]                 timer;
    logic [TW-1:0]                 tmo;
    logic [TW-1:0]                 hold_tmr;
    logic [TW-1:0]                 rec_tmr;
    logic [pee_pkg::LEN_W-1:0]     idx;
    logic [pee_pkg::LEN_W-1:0]     n_total;
    logic [2:0]                    n_pre;
    logic [1:0]                    op;
    logic [1:0]                    poll;
    logic [AW-1:0]                 base;
    logic [DW-1:0]                 last_data;
    logic                          prev_tog;
    logic                          have_prev;
    logic                          lock_active;
    logic [pee_pkg::PAGE_OFS_W-1:0] ram_addr;
    logic [DW-1:0]                 dq_s1;
    logic [DW-1:0]                 dq_s2;
    logic [DW-1:0]                 dq_s3;
    logic                          rdy_s1;
    logic                          rdy_s2;
    logic                          rdy_s3;
    logic [AW-1:0]                 addr;
    logic [DW-1:0]                 dq;
    logic                          dq_oe_n;
    logic                          ce_n;
    logic                          oe_n;
    logic                          we_n;
    logic                          res_n;
    logic                          cmd_ready;
    logic                          done;
    logic                          err;
    logic [DW-1:0]                 rdata;
    logic                          rdata_valid;
  } pee_regs_t;

  pee_regs_t         r;
  pee_regs_t         next_r;
  logic [DW-1:0]     ram_rdata;

  pee_page_ram #(
    .DATA_W (DW),
    .DEPTH  (pee_pkg::PAGE_BYTES)
  ) u_ram (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (buf_we_i),
    .wr_addr_i (buf_addr_i),
    .wr_data_i (buf_data_i),
    .rd_addr_i (r.ram_addr),
    .rd_data_o (ram_rdata)
  );

  // lock and unlock code bytes as {address, data}
  function automatic logic [AW+DW-1:0] code_byte(input logic [1:0] op,
                                                 input logic [2:0] i);
    logic [AW+DW-1:0] v;
    unique case (i)
      3'h1, 3'h4: v = {pee_pkg::CODE_ADDR_B, pee_pkg::CODE_DATA_B};
      3'h2:       v = (op == pee_pkg::CMD_UNLOCK) ?
                      {pee_pkg::CODE_ADDR_A, pee_pkg::CODE_DIS_C} : // RL19
                      {pee_pkg::CODE_ADDR_A, LOCK_CMD};            // RL24
      3'h5:       v = {pee_pkg::CODE_ADDR_A, pee_pkg::CODE_DIS_F}; // RL19
      default:    v = {pee_pkg::CODE_ADDR_A, pee_pkg::CODE_DATA_A};
    endcase
    return v;
  endfunction

  // next-state logic
  always_comb
  begin
    logic [pee_pkg::PAGE_OFS_W-1:0] off;
    logic [DW-1:0]                  smp;
    logic                           fin;
    logic                           accept;
    off    = '0;
    smp    = r.dq_s3;
    fin    = 1'b0;
    accept = cmd_valid_i && r.cmd_ready;
    next_r = r;
    next_r.done        = 1'b0;
    next_r.err         = 1'b0;
    next_r.rdata_valid = 1'b0;
    // three stages; only the agreeing second and third are used
    next_r.dq_s1  = mem_dq_i;
    next_r.dq_s2  = r.dq_s1;
    next_r.dq_s3  = r.dq_s2;
    next_r.rdy_s1 = mem_ready_i;
    next_r.rdy_s2 = r.rdy_s1;
    next_r.rdy_s3 = r.rdy_s2;
    if (r.timer != '0)
    begin
      next_r.timer = r.timer - 1'b1;
    end
    if (r.hold_tmr != '0)
    begin
      next_r.hold_tmr = r.hold_tmr - 1'b1;
    end
    if (r.tmo != '0)
    begin
      next_r.tmo = r.tmo - 1'b1;
    end
    unique case (r.state)
      PEE_IDLE:
      begin
        if (accept)
        begin
          next_r.op   = cmd_op_i;
          next_r.poll = poll_mode_i;
          next_r.base = cmd_addr_i;
          next_r.idx  = '0;
          unique case (cmd_op_i)
            pee_pkg::CMD_READ:
            begin
              next_r.addr  = cmd_addr_i;
              next_r.ce_n  = 1'b0;
              next_r.oe_n  = 1'b0;
              next_r.timer = TW'(pee_pkg::RD_CYC - 1);
              next_r.state = PEE_R_ACT;
            end
            pee_pkg::CMD_WRITE:
            begin
              // RL1
              if (cmd_len_i == '0 || cmd_len_i > pee_pkg::LEN_W'(pee_pkg::PAGE_BYTES))
              begin
                next_r.done = 1'b1;
                next_r.err  = 1'b1;
              end
              else
              begin
                next_r.n_pre   = r.lock_active ? pee_pkg::LOCK_LEN : 3'h0; // RL17
                next_r.n_total = cmd_len_i
                                 + (r.lock_active ? pee_pkg::LEN_W'(pee_pkg::LOCK_LEN)
                                                  : '0);
                next_r.state   = PEE_W_SETUP;
              end
            end
            default:
            begin
              next_r.n_pre   = (cmd_op_i == pee_pkg::CMD_LOCK) ?
                               pee_pkg::LOCK_LEN : pee_pkg::UNLOCK_LEN; // RL18
              next_r.n_total = (cmd_op_i == pee_pkg::CMD_LOCK) ?
                               pee_pkg::LEN_W'(pee_pkg::LOCK_LEN) :
                               pee_pkg::LEN_W'(pee_pkg::UNLOCK_LEN); // RL20
              next_r.state   = PEE_W_SETUP;
            end
          endcase
          if (next_r.state == PEE_W_SETUP)
          begin
            next_r.ram_addr = '0;
            next_r.timer    = TW'(pee_pkg::SETUP_CYC - 1);
            next_r.ce_n     = 1'b0;
          end
        end
      end
      PEE_W_SETUP:
      begin
        // address and data are driven on the same edge that drops the write strobe
        if (r.timer == '0)
        begin
          if (r.idx < pee_pkg::LEN_W'(r.n_pre))
          begin
            {next_r.addr, next_r.dq} = code_byte(r.op, r.idx[2:0]);
          end
          else
          begin
            off         = r.base[pee_pkg::PAGE_OFS_W-1:0]
                          + pee_pkg::PAGE_OFS_W'(r.idx - pee_pkg::LEN_W'(r.n_pre));
            next_r.addr = {r.base[AW-1:pee_pkg::PAGE_OFS_W], off}; // RL22
            next_r.dq   = ram_rdata;
          end
          next_r.dq_oe_n = 1'b0;
          next_r.we_n    = 1'b0; // RL14
          next_r.timer   = TW'(pee_pkg::WE_LOW_CYC - 1); // RL15
          next_r.state   = PEE_W_LOW;
        end
      end
      PEE_W_LOW:
      begin
        if (r.timer == '0)
        begin
          next_r.we_n      = 1'b1; // RL14
          next_r.last_data = r.dq;
          next_r.hold_tmr  = TW'(HOLD_CYC); // RL13
          next_r.timer     = TW'(pee_pkg::WE_HIGH_CYC - 1);
          next_r.state     = PEE_W_HIGH;
        end
      end
      PEE_W_HIGH:
      begin
        if (r.timer == '0)
        begin
          next_r.idx = r.idx + 1'b1;
          if (r.idx + 1'b1 < r.n_total)
          begin
            // next byte starts far inside the load deadline
            next_r.ram_addr = pee_pkg::PAGE_OFS_W'(r.idx + 1'b1
                                                   - pee_pkg::LEN_W'(r.n_pre)); // RL2
            next_r.timer    = TW'(pee_pkg::SETUP_CYC - 1);
            next_r.state    = PEE_W_SETUP;
          end
          else
          begin
            next_r.ce_n    = 1'b1; // RL16
            next_r.dq_oe_n = 1'b1;
            next_r.timer   = TW'(BL_CYC - 1); // RL3
            next_r.state   = PEE_WAIT_BL;
            if (r.op == pee_pkg::CMD_LOCK)
            begin
              next_r.lock_active = 1'b1; // RL18
            end
            else if (r.op == pee_pkg::CMD_UNLOCK)
            begin
              next_r.lock_active = 1'b0; // RL19
            end
          end
        end
      end
      PEE_WAIT_BL:
      begin
        // polling before the write starts would see stable data
        if (r.timer == '0)
        begin
          next_r.tmo       = TW'(WC_CYC); // RL23
          next_r.have_prev = 1'b0;
          next_r.ce_n      = 1'b0;
          next_r.oe_n      = 1'b0;
          next_r.timer     = TW'(pee_pkg::RD_CYC - 1);
          next_r.state     = PEE_R_ACT;
        end
      end
      PEE_R_ACT:
      begin
        // address stays at the last byte written for the whole poll
        if (r.timer == '0 && r.dq_s2 == r.dq_s3)
        begin
          next_r.ce_n = 1'b1;
          next_r.oe_n = 1'b1;
          if (r.op == pee_pkg::CMD_READ)
          begin
            next_r.rdata       = smp;
            next_r.rdata_valid = 1'b1;
            next_r.done        = 1'b1;
            next_r.state       = PEE_IDLE;
          end
          else
          begin
            next_r.prev_tog  = smp[pee_pkg::TOG_BIT];
            next_r.have_prev = 1'b1;
            unique case (r.poll)
              pee_pkg::POLL_DATA:
                fin = smp[pee_pkg::POLL_BIT] == r.last_data[pee_pkg::POLL_BIT]; // RL4
              pee_pkg::POLL_READY:
                fin = r.rdy_s2 && r.rdy_s3; // RL9
              default:
                fin = r.have_prev && smp[pee_pkg::TOG_BIT] == r.prev_tog; // RL5
            endcase
            if (fin || r.tmo == '0)
            begin
              next_r.done  = 1'b1;
              next_r.err   = !fin;
              next_r.state = PEE_IDLE;
            end
            else
            begin
              next_r.timer = TW'(pee_pkg::GAP_CYC - 1);
              next_r.state = PEE_R_GAP;
            end
          end
        end
      end
      PEE_R_GAP:
      begin
        if (r.timer == '0)
        begin
          next_r.ce_n  = 1'b0; // RL7
          next_r.oe_n  = 1'b0;
          next_r.timer = TW'(pee_pkg::RD_CYC - 1);
          next_r.state = PEE_R_ACT;
        end
      end
      default:
      begin
        next_r.state = PEE_IDLE;
      end
    endcase
    // reset pin only drops when idle and the post-load hold is over
    next_r.res_n = !(hold_prot_i && next_r.state == PEE_IDLE
                     && r.hold_tmr == '0 && !accept); // RL11 RL13
    if (!next_r.res_n)
    begin
      next_r.rec_tmr = TW'(pee_pkg::RES_HIGH_CYC);
    end
    else if (r.rec_tmr != '0)
    begin
      next_r.rec_tmr = r.rec_tmr - 1'b1;
    end
    next_r.cmd_ready = next_r.state == PEE_IDLE && next_r.res_n
                       && next_r.rec_tmr == '0 && !hold_prot_i; // RL10
  end

  // strobes idle high so the part stays unprogrammable; lock starts off
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r             <= '0;
      r.ce_n        <= 1'b1; // RL16
      r.oe_n        <= 1'b1;
      r.we_n        <= 1'b1;
      r.dq_oe_n     <= 1'b1;
      r.res_n       <= 1'b1;
      r.rec_tmr     <= TW'(pee_pkg::RES_HIGH_CYC);
      r.lock_active <= 1'b0; // RL21
    end
    else
    begin
      r <= next_r;
    end
  end

  assign cmd_ready_o       = r.cmd_ready;
  assign done_o            = r.done;
  assign err_o             = r.err;
  assign rdata_o           = r.rdata;
  assign rdata_valid_o     = r.rdata_valid;
  assign lock_active_o     = r.lock_active;
  assign mem_addr_o        = r.addr;
  assign mem_dq_o          = r.dq;
  assign mem_dq_oe_n_o     = r.dq_oe_n;
  assign mem_ce_n_o        = r.ce_n;
  assign mem_oe_n_o        = r.oe_n;
  assign mem_we_n_o        = r.we_n;
  assign protect_reset_n_o = r.res_n;

endmodule
`default_nettype wire

// ===== logic/pee_pkg.sv
// constants for the host-side write controller of a byte-wide parallel eeprom
// assumes a 250 MHz system clock; all pin timing derives from it except the fixed 2-cycle setup
package pee_pkg;

  // pin widths and page geometry
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned PAGE_OFS_W = 6;
  localparam int unsigned LEN_W      = 7;
  localparam int unsigned TMR_W      = 24;

  // clock period and pin timing in their own units
  localparam int unsigned CLK_PS         = 4000;
  localparam int unsigned T_WE_LOW_NS    = 200;
  localparam int unsigned T_WE_HIGH_NS   = 100;
  localparam int unsigned T_RD_NS        = 120;  // read access plus margin
  localparam int unsigned T_OE_GAP_NS    = 40;
  localparam int unsigned T_RES_HIGH_NS  = 1000;
  localparam int unsigned T_BLC_MAX_US   = 30;
  localparam int unsigned T_BL_US        = 100;
  localparam int unsigned T_WC_MS        = 10;
  localparam int unsigned T_HOLD_MS      = 10;

  // least times and the write-cycle timeout round up, the byte load limit rounds down
  localparam int unsigned WE_LOW_CYC   = (T_WE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WE_HIGH_CYC  = (T_WE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RD_CYC       = (T_RD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned GAP_CYC      = (T_OE_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned RES_HIGH_CYC = (T_RES_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SETUP_CYC    = 2;
  localparam int unsigned BLC_MAX_CYC  = (T_BLC_MAX_US * 1000000) / CLK_PS;
  localparam int unsigned BL_CYC       = (T_BL_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WC_CYC       = (T_WC_MS * 1000000 + CLK_PS / 1000 - 1)
                                         / (CLK_PS / 1000);
  localparam int unsigned HOLD_CYC     = (T_HOLD_MS * 1000000 + CLK_PS / 1000 - 1)
                                         / (CLK_PS / 1000);

  // command codes at the user port
  localparam logic [1:0] CMD_READ   = 2'h0;
  localparam logic [1:0] CMD_WRITE  = 2'h1;
  localparam logic [1:0] CMD_LOCK   = 2'h2;
  localparam logic [1:0] CMD_UNLOCK = 2'h3;

  // completion detection methods
  localparam logic [1:0] POLL_TOGGLE = 2'h0;
  localparam logic [1:0] POLL_DATA   = 2'h1;
  localparam logic [1:0] POLL_READY  = 2'h2;

  // status bit positions in the data byte
  localparam int unsigned TOG_BIT  = 6;
  localparam int unsigned POLL_BIT = 7;

  // write lock code bytes
  localparam logic [ADDR_W-1:0] CODE_ADDR_A  = 13'h1555;
  localparam logic [ADDR_W-1:0] CODE_ADDR_B  = 13'h0AAA;
  localparam logic [DATA_W-1:0] CODE_DATA_A  = 8'hAA;
  localparam logic [DATA_W-1:0] CODE_DATA_B  = 8'h55;
  localparam logic [DATA_W-1:0] CODE_DIS_C   = 8'h80;
  localparam logic [DATA_W-1:0] CODE_DIS_F   = 8'h20;
  localparam logic [DATA_W-1:0] CODE_LOCK_DF = 8'hA0;
  localparam logic [2:0]        LOCK_LEN     = 3'h3;
  localparam logic [2:0]        UNLOCK_LEN   = 3'h6;

endpackage

// ===== logic/pee_page_ram.sv
// page buffer for the eeprom host controller
// one write port from the user, one registered read port for the sequencer
`timescale 1ns/100ps
`default_nettype none

module pee_page_ram #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned DEPTH  = 64
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       wr_en_i,
  input  wire logic [$clog2(DEPTH)-1:0]   wr_addr_i,
  input  wire logic [DATA_W-1:0]          wr_data_i,
  input  wire logic [$clog2(DEPTH)-1:0]   rd_addr_i,
  output logic      [DATA_W-1:0]          rd_data_o
);

  if (DEPTH < 2 || DATA_W < 1)
  begin : g_chk
    $error("page ram needs at least two entries");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  // storage has no reset; contents are only read after the user fills them
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read costs one cycle, absorbed by the setup phase
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_data_o <= '0;
    end
    else
    begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule
`default_nettype wire

// ===== sim/pee_host_ctrl_assertions.sv
// assertions on the eeprom host controller ports
// bound into every pee_host_ctrl; one clock domain
`timescale 1ns/100ps
`default_nettype none
module pee_host_ctrl_chk #(
  parameter int unsigned HOLD_CYC = 100
) (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic        cmd_valid_i,
  input wire logic [1:0]  cmd_op_i,
  input wire logic [6:0]  cmd_len_i,
  input wire logic        hold_prot_i,
  input wire logic        cmd_ready_o,
  input wire logic        done_o,
  input wire logic        err_o,
  input wire logic [12:0] mem_addr_o,
  input wire logic [7:0]  mem_dq_o,
  input wire logic        mem_dq_oe_n_o,
  input wire logic        mem_ce_n_o,
  input wire logic        mem_we_n_o,
  input wire logic        protect_reset_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  wire         take = cmd_valid_i && cmd_ready_o;
  logic [23:0] since_we;
  logic [23:0] gap;
  logic        in_pg;
  // saturating counts from strobe edges; starts high so reset never fakes a hold
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      {since_we, gap, in_pg} <= {48'hFFFFFFFFFFFF, 1'b0};
    else
    begin
      since_we <= $rose(mem_we_n_o) ? 24'h0 : since_we + {23'h0, ~&since_we};
      gap      <= $fell(mem_we_n_o) ? 24'h0 : gap + {23'h0, ~&gap};
      in_pg    <= !cmd_ready_o && ($fell(mem_we_n_o) || in_pg);
    end
  a_bad_len_refused: assert property (
    take && cmd_op_i == pee_pkg::CMD_WRITE && (cmd_len_i == 7'h0 || cmd_len_i > 7'h40)
    |-> ##[1:2] done_o && err_o && mem_ce_n_o) else $error("bad length taken");
  a_we_width: assert property ($fell(mem_we_n_o) |-> ##50 $rose(mem_we_n_o))
    else $error("strobe width wrong");
  a_latch_steady: assert property ($rose(mem_we_n_o) |-> $stable(mem_addr_o)
    && $stable(mem_dq_o) && !mem_dq_oe_n_o) else $error("latch values moved");
  a_write_strobes: assert property (!mem_we_n_o |-> !mem_ce_n_o)
    else $error("strobe without select");
  a_load_gap: assert property ($fell(mem_we_n_o) && in_pg
    |-> gap <= 24'(pee_pkg::BLC_MAX_CYC)) else $error("byte load gap long");
  a_prot_quiet: assert property (!protect_reset_n_o |-> mem_ce_n_o && !cmd_ready_o)
    else $error("access in protect");
  a_prot_hold: assert property ($fell(protect_reset_n_o) |-> since_we >= 24'(HOLD_CYC - 2))
    else $error("protect too early");
  a_prot_release: assert property ($fell(hold_prot_i) |-> ##[1:2] protect_reset_n_o)
    else $error("protect not released");
  cover property (take && cmd_op_i == pee_pkg::CMD_LOCK);
  cover property (done_o && err_o);
  cover property (!protect_reset_n_o);
endmodule
bind pee_host_ctrl pee_host_ctrl_chk #(.HOLD_CYC(HOLD_CYC)) u_chk (.*);
`default_nettype wire

// ===== sim/pee_eeprom_model.sv
// behavioural byte-wide eeprom with page load, polling bits and write lock
// timers run on the bench clock; window and write time are shortened
`timescale 1ns/100ps
`default_nettype none
module pee_eeprom_model #(
  parameter int         BL       = 40,
  parameter int         WC       = 200,
  parameter logic [7:0] LOCK_CMD = 8'hA0
) (
  input  wire logic        clk_i,
  input  wire logic [12:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        res_n_i,
  output logic      [7:0]  dq_o,
  output logic             drv_o,
  output logic             rdy_o
);
  logic [7:0]  m [8192];
  logic [7:0]  pg [64];
  logic [63:0] pv = '0;
  logic [12:0] la, pa;
  logic [7:0]  last = '0;
  logic [2:0]  s = '0;
  logic [3:0]  lo = '0;
  int          bl = 0, wc = 0, i;
  logic        ld = 0, busy = 0, lock = 0, tog = 0, rd_d = 0;
  wire         wr = !ce_n_i && !we_n_i;
  wire  [20:0] k = {la, dq_i};
  wire  [20:0] code = s == 0 || s == 3 ? 21'h1555AA : s == 1 || s == 4 ? 21'h0AAA55
                    : s == 2 ? 21'h155580 : 21'h155520;
  assign drv_o = !ce_n_i && !oe_n_i && we_n_i && res_n_i;
  assign dq_o  = busy ? {~last[7], tog, last[5:0]} : m[addr_i];
  assign rdy_o = !(busy || ld);
  initial foreach (m[j]) m[j] = 8'hFF;
  // short low pulses are filtered so a glitch never loads a byte
  always @(posedge clk_i)
  begin
    lo   <= wr ? lo + {3'h0, lo != 4'hF} : 4'h0;
    rd_d <= drv_o;
    bl   <= wr ? 0 : bl + 1;
    wc   <= wc + 1;
    if (busy && drv_o && !rd_d)
      tog <= ~tog;
    if (wr && lo == 4'h4 && res_n_i && !busy)
      la <= addr_i;
    if (!wr && lo > 4'h4 && res_n_i && !busy)
    begin
      ld <= 1'b1;
      if (pv == '0)
        pa <= la;
      if (s == 3'h2 && k == {13'h1555, LOCK_CMD})
        {lock, s} <= 4'hF;
      else if (k == code && s == 3'h5)
        {lock, s} <= 4'h6;
      else if (k == code && s < 3'h5)
        s <= s + 3'h1;
      else if (!lock || s == 3'h7)
      begin
        pg[la[5:0]] <= dq_i;
        pv[la[5:0]] <= 1'b1;
        {last, s}   <= {dq_i, 3'h7};
      end
    end
    if (busy && !res_n_i)
      {busy, ld, pv} <= '0;
    else if (busy && wc == WC)
    begin
      for (i = 0; i < 64; i++)
        if (pv[i])
          m[{pa[12:6], i[5:0]}] <= pg[i];
      {busy, ld, pv} <= '0;
    end
    else if (ld && !busy && bl == BL)
      {busy, tog, wc, s} <= {2'b10, 32'h0, 3'h0};
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench: host controller against the eeprom model
// controller window longer than the model's; short write and hold times
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_sys_i = 0, arst_n_i = 0, buf_we_i = 0, cmd_valid_i = 0, hold_prot_i = 0;
  logic [5:0]  buf_addr_i = '0;
  logic [7:0]  buf_data_i = '0, rdata_o, mem_dq_o, mem_dq_i, mdl_dq, g_rd;
  logic [1:0]  cmd_op_i = '0, poll_mode_i = '0;
  logic [12:0] cmd_addr_i = '0, mem_addr_o;
  logic [6:0]  cmd_len_i = '0;
  logic        cmd_ready_o, done_o, err_o, rdata_valid_o, lock_active_o, mem_dq_oe_n_o;
  logic        mem_ce_n_o, mem_oe_n_o, mem_we_n_o, protect_reset_n_o, mem_ready_i, mdl_drv;
  int          mismatches = 0, check_count = 0;
  // floating bus shows a changing pattern
  assign mem_dq_i = !mem_dq_oe_n_o ? mem_dq_o : mdl_drv ? mdl_dq : 8'hA5 ^ {8{clk_sys_i}};
  pee_host_ctrl #(.BL_CYC(60), .WC_CYC(2000), .HOLD_CYC(100)) u_dut (.*);
  pee_eeprom_model u_mem (.clk_i(clk_sys_i), .addr_i(mem_addr_o), .dq_i(mem_dq_o),
    .ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o),
    .res_n_i(protect_reset_n_o), .dq_o(mdl_dq), .drv_o(mdl_drv), .rdy_o(mem_ready_i));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one command: ready, valid over the taking edge, then done; hangs go to the watchdog
  task automatic cmd(input logic [1:0] op, input logic [12:0] a, input logic [6:0] n,
                     input logic [1:0] pm);
    do @(negedge clk_sys_i); while (cmd_ready_o !== 1'b1);
    @(posedge clk_sys_i);
    {cmd_valid_i, cmd_op_i, cmd_addr_i, cmd_len_i, poll_mode_i} <= {1'b1, op, a, n, pm};
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    do @(negedge clk_sys_i); while (done_o !== 1'b1);
    g_rd = err_o ? 8'hEE : rdata_valid_o ? rdata_o : 8'hD0;
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
    cmd(pee_pkg::CMD_READ, a, 7'h1, pee_pkg::POLL_TOGGLE);
    chk(g_rd, e);
  endtask
  task automatic wr(input logic [7:0] d, input int n, input logic [12:0] a,
                    input logic [1:0] pm);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys_i);
      {buf_we_i, buf_addr_i, buf_data_i} <= {1'b1, i[5:0], d + i[7:0]};
    end
    @(posedge clk_sys_i);
    buf_we_i <= 1'b0;
    cmd(pee_pkg::CMD_WRITE, a, n[6:0], pm);
  endtask
  // hang guard, several times the expected run
  initial
  begin
    #240000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    wr(8'h10, 64, 13'h0045, pee_pkg::POLL_TOGGLE);
    chk(g_rd, 8'hD0);
    rdchk(13'h0045, 8'h10);
    rdchk(13'h0044, 8'h4F);
    rdchk(13'h0080, 8'hFF);
    wr(8'hC3, 1, 13'h0100, pee_pkg::POLL_DATA);
    rdchk(13'h0100, 8'hC3);
    cmd(pee_pkg::CMD_LOCK, 13'h0, 7'h1, pee_pkg::POLL_TOGGLE);
    chk({7'h0, lock_active_o}, 8'h01);
    wr(8'h5A, 1, 13'h0200, pee_pkg::POLL_READY);
    rdchk(13'h0200, 8'h5A);
    cmd(pee_pkg::CMD_UNLOCK, 13'h0, 7'h1, pee_pkg::POLL_TOGGLE);
    chk({7'h0, lock_active_o}, 8'h00);
    rdchk(13'h1555, 8'hFF);
    cmd(pee_pkg::CMD_WRITE, 13'h0, 7'h0, pee_pkg::POLL_TOGGLE);
    chk(g_rd, 8'hEE);
    cmd(pee_pkg::CMD_WRITE, 13'h0, 7'h41, pee_pkg::POLL_TOGGLE);
    chk(g_rd, 8'hEE);
    @(posedge clk_sys_i);
    hold_prot_i <= 1'b1;
    repeat (150) @(negedge clk_sys_i);
    chk({6'h0, protect_reset_n_o, cmd_ready_o}, 8'h00);
    @(posedge clk_sys_i);
    hold_prot_i <= 1'b0;
    rdchk(13'h0100, 8'hC3);
    stop_test();
  end
endmodule
`default_nettype wire
